// ---- shared/sdh_inhibit_cfg.svh ----
// constants for the sd host inhibit and voltage control block
// assumes a 32-bit apb slave with 12 address bits and byte strobes
`ifndef SDH_INHIBIT_CFG_SVH
`define SDH_INHIBIT_CFG_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define SDH_OFS_CMD 12'h20C
`define SDH_OFS_PSTATE 12'h224
`define SDH_OFS_HCTL 12'h228
`define SDH_OFS_IRQ_STAT 12'h230
`define SDH_OFS_IRQ_MASK 12'h234

// ----------------------------------------
// field positions
// ----------------------------------------
`define SDH_PS_COMMAND_LINE_INHIBIT 0
`define SDH_PS_DATI 1
`define SDH_PS_DLA 2
`define SDH_PS_RTA 9
`define SDH_VS_LSB 9
`define SDH_VS_MSB 11
`define SDH_RSP_LSB 16
`define SDH_RSP_MSB 17
`define SDH_IRQ_CC 0
`define SDH_IRQ_TC 1
`define SDH_CMD_MSB_LANE 3

// ----------------------------------------
// codes and reset values
// ----------------------------------------
`define SDH_VS_1V8 3'h5
`define SDH_VS_3V0 3'h6
`define SDH_VS_3V3 3'h7
`define SDH_RSP_NONE 2'h0
`define SDH_RSP_BUSY 2'h3
`define SDH_HCTL_RESET 3'h0
`define SDH_CMD_RESET 2'h0
`define SDH_IRQ_RESET 2'h0

// ----------------------------------------
// timing
// ----------------------------------------
`define SDH_BUSY_IDLE_EDGES 4'h8

`endif

// ---- shared/sdh_pkg.sv ----
// types for the sd host inhibit and voltage control block
// assumes the controller core drives events as one-cycle core_clk pulses
package sdh_pkg;

    // events from the command and data engines, one-cycle pulses
    typedef struct packed {
        logic cmdEndBit;
        logic rspEndBit;
        logic commandCrcError;
        logic commandEndBitError;
        logic autoStopNotExecuted;
        logic commandTimeoutError;
        logic readCmdEnd;
        logic writeCmdEnd;
        logic continueReq;
        logic dataEnd;
        logic readWaitStart;
        logic lastBlockRead;
        logic stopAtGap;
    } sdh_ctrl_ev_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } sdh_apb_rsp_t;

endpackage

// ---- verilog/sdh_inhibit_ctl.sv ----
// command and data inhibit flags, bus voltage select and their apb regs
// assumes events arrive on core_clk; card pins arrive asynchronously
`timescale 1ns/1ps
`include "sdh_inhibit_cfg.svh"

module sdh_inhibit_ctl
    import sdh_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire sdh_ctrl_ev_t ctrlEv,
    input wire logic linkClkPin,
    input wire logic dat0Pin,
    output logic irq,
    output logic [2:0] busVoltageSel,
    output logic commandLineInhibit,
    output logic dataLineInhibit
);

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    function automatic logic isMapped(input logic [11:0] a);
        isMapped = (a == `SDH_OFS_CMD) || (a == `SDH_OFS_PSTATE) ||
            (a == `SDH_OFS_HCTL) || (a == `SDH_OFS_IRQ_STAT) ||
            (a == `SDH_OFS_IRQ_MASK);
    endfunction

    function automatic logic isWriteTo(input logic [11:0] a,
        input logic [11:0] ofs, input logic acc, input logic wr);
        isWriteTo = acc && wr && (a == ofs);
    endfunction

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    logic accessDone;
    logic cmdWrite;
    logic hctlWrite;
    logic statWrite;
    logic maskWrite;
    logic cmdIssue;
    logic [1:0] rspKindNew;
    logic [1:0] rspKind_reg;
    logic [2:0] voltSel_reg;
    logic cmdInhibit_reg;
    logic cmdInhibitClear;
    logic dataActive_reg;
    logic readActive_reg;
    logic busyPending_reg;
    logic busyArmed_reg;
    logic [3:0] idleEdges_reg;
    logic dataInhibit_next;
    logic dataInhibit_reg;
    logic [1:0] irqStat_reg;
    logic [1:0] irqMask_reg;
    logic [1:0] irqEvent;
    logic [1:0] pinRaw;
    logic [1:0] pinS1_reg;
    logic [1:0] pinS2_reg;
    logic [1:0] pinS3_reg;
    logic [1:0] pinFilt_reg;
    logic linkClkPrev_reg;
    logic linkRise;
    logic [31:0] readValue;
    sdh_apb_rsp_t rsp_reg;

    // ----------------------------------------
    // apb slave: one wait state, answer from a flop
    // ----------------------------------------
    assign accessDone = psel && penable && rsp_reg.pready;
    assign cmdWrite = isWriteTo(paddr, `SDH_OFS_CMD, accessDone, pwrite);
    assign hctlWrite = isWriteTo(paddr, `SDH_OFS_HCTL, accessDone, pwrite);
    assign statWrite = isWriteTo(paddr, `SDH_OFS_IRQ_STAT, accessDone,
        pwrite);
    assign maskWrite = isWriteTo(paddr, `SDH_OFS_IRQ_MASK, accessDone,
        pwrite);

    always_comb
    begin
        readValue = 32'h0000_0000;
        unique case (paddr)
            `SDH_OFS_CMD:
            begin
                readValue[`SDH_RSP_MSB:`SDH_RSP_LSB] = rspKind_reg;
            end
            `SDH_OFS_PSTATE:
            begin
                readValue[`SDH_PS_COMMAND_LINE_INHIBIT] = cmdInhibit_reg;
                readValue[`SDH_PS_DATI] = dataInhibit_reg;
                readValue[`SDH_PS_DLA] = dataActive_reg;
                readValue[`SDH_PS_RTA] = readActive_reg;
            end
            `SDH_OFS_HCTL:
            begin
                // upper and lower reserved bits stay zero
                readValue[`SDH_VS_MSB:`SDH_VS_LSB] = voltSel_reg;
            end
            `SDH_OFS_IRQ_STAT:
            begin
                readValue[1:0] = irqStat_reg;
            end
            `SDH_OFS_IRQ_MASK:
            begin
                readValue[1:0] = irqMask_reg;
            end
            default:
            begin
                readValue = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            rsp_reg <= '0;
        end
        else
        begin
            // pready rises in the second access cycle, then drops
            rsp_reg.pready <= psel && penable && !rsp_reg.pready;
            if (psel && penable && !rsp_reg.pready)
            begin
                rsp_reg.pslverr <= !isMapped(paddr);
                rsp_reg.prdata <= pwrite ? 32'h0000_0000 : readValue;
            end
            else
            begin
                rsp_reg.pslverr <= 1'b0;
                rsp_reg.prdata <= 32'h0000_0000;
            end
        end
    end

    assign prdata = rsp_reg.prdata;
    assign pready = rsp_reg.pready;
    assign pslverr = rsp_reg.pslverr;

    // ----------------------------------------
    // host control: bus voltage select
    // ----------------------------------------
    // any code may be written; software must pick a supported level
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            voltSel_reg <= `SDH_HCTL_RESET;
        end
        else if (hctlWrite && pstrb[1])
        begin
            voltSel_reg <= pwdata[`SDH_VS_MSB:`SDH_VS_LSB];
        end
    end

    assign busVoltageSel = voltSel_reg;

    // ----------------------------------------
    // command register: response kind and issue strobe
    // ----------------------------------------
    assign rspKindNew = pstrb[2] ? pwdata[`SDH_RSP_MSB:`SDH_RSP_LSB] :
        rspKind_reg;
    // the top byte write is the issue; lower bytes only stage fields
    assign cmdIssue = cmdWrite && pstrb[`SDH_CMD_MSB_LANE];

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            rspKind_reg <= `SDH_CMD_RESET;
        end
        else if (cmdWrite)
        begin
            rspKind_reg <= rspKindNew;
        end
    end

    // ----------------------------------------
    // command line inhibit
    // ----------------------------------------
    // an automatic stop command has no path here, so it never sets it
    always_comb
    begin
        cmdInhibitClear = 1'b0;
        if (!ctrlEv.commandTimeoutError)
        begin
            if (ctrlEv.rspEndBit && !ctrlEv.commandCrcError &&
                !ctrlEv.commandEndBitError &&
                !ctrlEv.autoStopNotExecuted)
            begin
                cmdInhibitClear = 1'b1;
            end
            if (ctrlEv.cmdEndBit && rspKind_reg == `SDH_RSP_NONE)
            begin
                cmdInhibitClear = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            cmdInhibit_reg <= 1'b0;
        end
        else if (cmdIssue)
        begin
            // issue wins over a clear in the same cycle
            cmdInhibit_reg <= 1'b1;
        end
        else if (cmdInhibitClear)
        begin
            cmdInhibit_reg <= 1'b0;
        end
    end

    assign commandLineInhibit = cmdInhibit_reg;

    // ----------------------------------------
    // data active and read active
    // ----------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            dataActive_reg <= 1'b0;
        end
        else if (ctrlEv.readCmdEnd || ctrlEv.writeCmdEnd ||
            ctrlEv.continueReq)
        begin
            dataActive_reg <= 1'b1;
        end
        else if (ctrlEv.dataEnd || ctrlEv.readWaitStart)
        begin
            dataActive_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            readActive_reg <= 1'b0;
        end
        else if (ctrlEv.readCmdEnd || ctrlEv.continueReq)
        begin
            readActive_reg <= 1'b1;
        end
        else if (ctrlEv.lastBlockRead || ctrlEv.stopAtGap)
        begin
            readActive_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // card pin synchronisers, three flops and agreement filter
    // ----------------------------------------
    assign pinRaw = {dat0Pin, linkClkPin};

    generate
        for (genvar i = 0; i < 2; i++)
        begin : g_sync
            always_ff @(posedge core_clk)
            begin
                if (reset)
                begin
                    pinS1_reg[i] <= 1'b0;
                    pinS2_reg[i] <= 1'b0;
                    pinS3_reg[i] <= 1'b0;
                    pinFilt_reg[i] <= 1'b1;
                end
                else
                begin
                    pinS1_reg[i] <= pinRaw[i];
                    pinS2_reg[i] <= pinS1_reg[i];
                    pinS3_reg[i] <= pinS2_reg[i];
                    if (pinS2_reg[i] == pinS3_reg[i])
                    begin
                        pinFilt_reg[i] <= pinS3_reg[i];
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            linkClkPrev_reg <= 1'b1;
        end
        else
        begin
            linkClkPrev_reg <= pinFilt_reg[0];
        end
    end

    assign linkRise = pinFilt_reg[0] && !linkClkPrev_reg;

    // ----------------------------------------
    // busy after a busy-type command
    // ----------------------------------------
    // busy ends only after dat0 stays high for eight rising link clock edges, or when a command that is not busy-type is issued;
    // a stopped link clock therefore keeps the flag up, which is safe
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            busyPending_reg <= 1'b0;
            busyArmed_reg <= 1'b0;
            idleEdges_reg <= 4'h0;
        end
        else if (cmdIssue)
        begin
            busyPending_reg <= (rspKindNew == `SDH_RSP_BUSY);
            busyArmed_reg <= 1'b0;
            idleEdges_reg <= 4'h0;
        end
        else if (busyPending_reg)
        begin
            if (ctrlEv.rspEndBit)
            begin
                busyArmed_reg <= 1'b1;
            end
            if (busyArmed_reg && linkRise)
            begin
                if (!pinFilt_reg[1])
                begin
                    idleEdges_reg <= 4'h0;
                end
                else if (idleEdges_reg == `SDH_BUSY_IDLE_EDGES - 4'h1)
                begin
                    busyPending_reg <= 1'b0;
                    busyArmed_reg <= 1'b0;
                    idleEdges_reg <= 4'h0;
                end
                else
                begin
                    idleEdges_reg <= idleEdges_reg + 4'h1;
                end
            end
        end
    end

    // ----------------------------------------
    // data line inhibit
    // ----------------------------------------
    assign dataInhibit_next = dataActive_reg || readActive_reg ||
        busyPending_reg;

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            dataInhibit_reg <= 1'b0;
        end
        else
        begin
            dataInhibit_reg <= dataInhibit_next;
        end
    end

    assign dataLineInhibit = dataInhibit_reg;

    // ----------------------------------------
    // interrupt status, mask and output
    // ----------------------------------------
    assign irqEvent[`SDH_IRQ_TC] = dataInhibit_reg &&
        !dataInhibit_next;
    assign irqEvent[`SDH_IRQ_CC] = cmdInhibit_reg && cmdInhibitClear &&
        !cmdIssue;

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            irqStat_reg <= `SDH_IRQ_RESET;
        end
        else
        begin
            // a new event outranks a write-one clear in the same cycle
            irqStat_reg <= (irqStat_reg &
                ~((statWrite && pstrb[0]) ? pwdata[1:0] : 2'h0)) |
                irqEvent;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            irqMask_reg <= `SDH_IRQ_RESET;
        end
        else if (maskWrite && pstrb[0])
        begin
            irqMask_reg <= pwdata[1:0];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(irqStat_reg & irqMask_reg);
        end
    end

endmodule

// ---- verification/sdh_card_model.sv ----
// card side model: link clock inside frames, busy on data line 0
// assumes the bench says when a frame runs and when the card is busy
`timescale 1ns/1ps

module sdh_card_model
(
    input wire logic run,
    input wire logic busy,
    output logic linkClkPin,
    output logic dat0Pin
);
    // link clock stands low outside frames; odd start keeps phase unrelated
    initial
    begin
        linkClkPin = 1'h0;
        #7;
        forever
        begin
            #80;
            linkClkPin = run ? !linkClkPin : 1'h0;
        end
    end

    // line has a pull-up, so a card that lets go reads high
    assign dat0Pin = !busy;
endmodule

// ---- verification/sdh_inhibit_ctl_sva.sv ----
// assertions on the inhibit flags, voltage select and apb answer
// assumes it is bound to sdh_inhibit_ctl and sees only its ports
`timescale 1ns/1ps
`include "sdh_inhibit_cfg.svh"

module sdh_inhibit_ctl_sva
    import sdh_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire sdh_ctrl_ev_t ctrlEv,
    input wire logic linkClkPin,
    input wire logic dat0Pin,
    input wire logic irq,
    input wire logic [2:0] busVoltageSel,
    input wire logic commandLineInhibit,
    input wire logic dataLineInhibit
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);

    logic wrDone;
    logic issue;
    logic hctlWr;
    logic rspErr;
    assign wrDone = psel && penable && pready && pwrite;
    assign issue = wrDone && paddr == `SDH_OFS_CMD && pstrb[3];
    assign hctlWr = wrDone && paddr == `SDH_OFS_HCTL && pstrb[1];
    assign rspErr = ctrlEv.commandCrcError || ctrlEv.commandEndBitError
        || ctrlEv.autoStopNotExecuted;

    sequence sAccess;
        psel && !penable ##1 psel && penable;
    endsequence

    AST_READY_WAIT: assert property (sAccess |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_COMMAND_LINE_INHIBIT_ISSUE: assert property (issue |=> commandLineInhibit)
        else $error("command inhibit not set by issue");
    AST_COMMAND_LINE_INHIBIT_RSP_CLEAR: assert property (ctrlEv.rspEndBit && !rspErr
        && !ctrlEv.commandTimeoutError && !issue |=> !commandLineInhibit)
        else $error("command inhibit not cleared by response");
    AST_COMMAND_LINE_INHIBIT_ERR_HOLD: assert property (commandLineInhibit
        && ctrlEv.rspEndBit && rspErr && !ctrlEv.cmdEndBit
        |=> commandLineInhibit)
        else $error("command inhibit cleared despite error");
    AST_COMMAND_LINE_INHIBIT_TIMEOUT: assert property (commandLineInhibit
        && ctrlEv.commandTimeoutError |=> commandLineInhibit)
        else $error("command inhibit cleared on timeout");
    AST_DATI_SET: assert property (ctrlEv.readCmdEnd
        && !ctrlEv.stopAtGap |-> ##[1:2] dataLineInhibit)
        else $error("data inhibit not set by read command");
    AST_VS_LOAD: assert property (hctlWr
        |=> busVoltageSel == $past(pwdata[11:9]))
        else $error("voltage select not loaded");
    AST_VS_HOLD: assert property (!hctlWr |=> $stable(busVoltageSel))
        else $error("voltage select changed without write");
    AST_HCTL_RSV_ZERO: assert property (pready && !pwrite
        && paddr == `SDH_OFS_HCTL |-> prdata[31:12] == 20'h0
        && prdata[8:0] == 9'h0)
        else $error("reserved host control bits not zero");
endmodule

// ---- verification/tb_sd_host_inhibit_and_voltage_ctl.sv ----
// self-checking bench for the inhibit flags and bus voltage select
// assumes the card model on the pins and apb access from these tasks
`timescale 1ns/1ps
`include "sdh_inhibit_cfg.svh"

module tb_sd_host_inhibit_and_voltage_ctl
    import sdh_pkg::*;
;
    logic core_clk, reset, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    sdh_ctrl_ev_t ctrlEv, e;
    logic linkClkPin, dat0Pin, irq, cmdInh, datInh, cardRun, cardBusy;
    logic [2:0] busVoltageSel;
    int error_cnt, n_tests, cycles, n;

    sdh_inhibit_ctl dut (.core_clk(core_clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ctrlEv(ctrlEv), .linkClkPin(linkClkPin), .dat0Pin(dat0Pin),
        .irq(irq), .busVoltageSel(busVoltageSel),
        .commandLineInhibit(cmdInh), .dataLineInhibit(datInh));
    sdh_card_model card (.run(cardRun), .busy(cardBusy),
        .linkClkPin(linkClkPin), .dat0Pin(dat0Pin));

    always #10 core_clk = !core_clk;

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic results();
        if (error_cnt == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chkBit(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask

    // idle edge first, so back-to-back calls never drive psel twice
    task automatic apb(input logic [11:0] a, input logic w,
        input logic [31:0] d, input logic [3:0] s);
        @(posedge core_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge core_clk);
        penable <= 1'h1;
        do
            @(posedge core_clk);
        while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
        apb(a, 1'h0, 32'h0, 4'h0);
        chk(rd, exp);
    endtask

    task automatic ev(input sdh_ctrl_ev_t x);
        @(posedge core_clk);
        ctrlEv <= x;
        @(posedge core_clk);
        ctrlEv <= '0;
        repeat (2) @(posedge core_clk);
    endtask

    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            error_cnt++;
            results();
        end
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        {core_clk, psel, penable, pwrite, cardRun, cardBusy} = 6'h0;
        {paddr, pwdata, pstrb} = 48'h0;
        ctrlEv = '0;
        reset = 1'h1;
        {error_cnt, n_tests} = 64'h0;
        repeat (12) @(posedge core_clk);
        reset <= 1'h0;
        rdChk(`SDH_OFS_HCTL, 32'h0);
        rdChk(`SDH_OFS_PSTATE, 32'h0);
        for (int v = 5; v < 8; v++)
        begin
            apb(`SDH_OFS_HCTL, 1'h1, 32'hFFFFF1FF | (v << 9), 4'hF);
            rdChk(`SDH_OFS_HCTL, v << 9);
            chk({29'h0, busVoltageSel}, v);
        end
        apb(`SDH_OFS_HCTL, 1'h1, {20'h0, `SDH_VS_1V8, 9'h0}, 4'h2);
        rdChk(`SDH_OFS_HCTL, {20'h0, `SDH_VS_1V8, 9'h0});
        chk({29'h0, busVoltageSel}, {29'h0, `SDH_VS_1V8});
        apb(12'h100, 1'h0, 32'h0, 4'h0);
        chk({rd[30:0], err}, 32'h1);
        apb(`SDH_OFS_IRQ_MASK, 1'h1, 32'h3, 4'h1);
        // each response error, then timeout, must hold the flag;
        // last pass: command end alone while a response is still due
        for (int i = 0; i < 6; i++)
        begin
            apb(`SDH_OFS_CMD, 1'h1, (i != 4) ? 32'h10000 : 32'h0, 4'hC);
            // flag is launched on the edge that ends the access
            @(posedge core_clk);
            chkBit(cmdInh, 1'h1);
            e = '0;
            e.rspEndBit = (i < 4);
            e.cmdEndBit = (i > 3);
            e.commandCrcError = (i == 0);
            e.commandEndBitError = (i == 1);
            e.autoStopNotExecuted = (i == 2);
            e.commandTimeoutError = (i == 3) || (i == 4);
            ev(e);
            chkBit(cmdInh, 1'h1);
            e = '0;
            e.rspEndBit = (i != 4);
            e.cmdEndBit = (i == 4);
            ev(e);
            chkBit(cmdInh, 1'h0);
        end
        rdChk(`SDH_OFS_IRQ_STAT, 32'h1);
        chkBit(irq, 1'h1);
        apb(`SDH_OFS_IRQ_STAT, 1'h1, 32'h1, 4'h1);
        e = '0;
        e.readCmdEnd = 1'h1;
        ev(e);
        chkBit(datInh, 1'h1);
        rdChk(`SDH_OFS_PSTATE, 32'h206);
        chkBit(irq, 1'h0);
        e = '0;
        e.dataEnd = 1'h1;
        ev(e);
        chkBit(datInh, 1'h1);
        e = '0;
        e.lastBlockRead = 1'h1;
        ev(e);
        chkBit(datInh, 1'h0);
        rdChk(`SDH_OFS_IRQ_STAT, 32'h2);
        chkBit(irq, 1'h1);
        apb(`SDH_OFS_IRQ_STAT, 1'h1, 32'h2, 4'h1);
        // busy command: card holds line 0 low while the link clock runs
        cardBusy <= 1'h1;
        cardRun <= 1'h1;
        apb(`SDH_OFS_CMD, 1'h1, 32'h30000, 4'hC);
        repeat (3) @(posedge core_clk);
        chkBit(datInh, 1'h1);
        e = '0;
        e.rspEndBit = 1'h1;
        ev(e);
        repeat (40) @(posedge core_clk);
        chkBit(datInh, 1'h1);
        cardBusy <= 1'h0;
        repeat (40) @(posedge core_clk);
        chkBit(datInh, 1'h1);
        n = 0;
        while (datInh !== 1'h0 && n < 100)
        begin
            @(posedge core_clk);
            n++;
        end
        chkBit(datInh, 1'h0);
        cardRun <= 1'h0;
        rdChk(`SDH_OFS_IRQ_STAT, 32'h3);
        results();
    end
endmodule

bind sdh_inhibit_ctl sdh_inhibit_ctl_sva chk_i (.core_clk(core_clk),
    .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ctrlEv(ctrlEv),
    .linkClkPin(linkClkPin), .dat0Pin(dat0Pin), .irq(irq),
    .busVoltageSel(busVoltageSel), .commandLineInhibit(commandLineInhibit),
    .dataLineInhibit(dataLineInhibit));
